/* hw/slbm_defs.vh */
`ifndef SLBM_DEFS_VH
`define SLBM_DEFS_VH
// register byte offsets
`define SLBM_REG_BIAS_AMOUNT   8'h00
`define SLBM_REG_BIAS_WIDTH    8'h04
`define SLBM_REG_MODE_SELECT   8'h08
`define SLBM_REG_TORQUE_THR    8'h0c
`define SLBM_REG_SPEED_THR     8'h10
`define SLBM_REG_ACCEL_THR     8'h14
`define SLBM_REG_ERROR_THR     8'h18
`define SLBM_REG_AUTOTUNE_CFG  8'h1c
`define SLBM_REG_COMP_PERCENT  8'h20
`define SLBM_REG_INTEG_TIME    8'h24
`define SLBM_REG_CONTROL       8'h28
`define SLBM_REG_STATUS        8'h2c
// reset values and limits
`define SLBM_BIAS_AMOUNT_RST   16'h0000
`define SLBM_BIAS_AMOUNT_MAX   16'h01c2
`define SLBM_BIAS_WIDTH_RST    16'h0007
`define SLBM_BIAS_WIDTH_MAX    16'h00fa
`define SLBM_MODE_SELECT_RST   3'h0
`define SLBM_TORQUE_THR_RST    16'h00c8
`define SLBM_AUTOTUNE_RST      16'h0000
`define SLBM_AUTOTUNE_OFF      16'h0002
`define SLBM_COMP_PERCENT_RST  16'h0064
`define SLBM_INTEG_TIME_RST    16'h07d0
// mode switch selector codes
`define SLBM_SEL_TORQUE        3'h0
`define SLBM_SEL_SPEED         3'h1
`define SLBM_SEL_ACCEL         3'h2
`define SLBM_SEL_ERROR         3'h3
`define SLBM_SEL_NONE          3'h4
// compensation select digit, bits 7:4 of autotune config
`define SLBM_COMP_DIGIT_LSB    4
`define SLBM_COMP_DISABLE      4'h1
// integral time unit in ns and cycles per unit at 200 MHz
`define SLBM_CLK_PERIOD_NS     5
`define SLBM_INTEG_UNIT_NS     10000
`define SLBM_INTEG_UNIT_CYC    (`SLBM_INTEG_UNIT_NS / `SLBM_CLK_PERIOD_NS)
`endif

/* hw/slbm_tick_div.v */
`timescale 1ns/1ps
// one-cycle enable every DIV clocks
module slbm_tick_div #(
  parameter DIV = 2000
) (
  input wire i_core_clk,
  input wire i_reset,
  output reg o_tick
);
  reg [15:0] cnt_q;
  // count down and pulse at zero
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_q <= 16'h0000;
      o_tick <= 1'b0;
    end else if (cnt_q == 16'h0000) begin
      cnt_q <= DIV[15:0] - 16'h0001;
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule // slbm_tick_div

/* hw/slbm_sync3.v */
`timescale 1ns/1ps
// three-stage synchroniser; output changes when stages two and three agree
module slbm_sync3 #(
  parameter W = 1
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  genvar g;
  // per-bit chain with agreement filter
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge i_core_clk) begin
        if (i_reset) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          s1_q[g] <= i_async[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            o_sync[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate
endmodule // slbm_sync3

/* hw/slbm_speed_loop.v */
`timescale 1ns/1ps
`include "slbm_defs.vh"
// Function
// RULE1: add speed bias only while position error magnitude exceeds the bias width
// RULE2: bias amount 0 to 450 r/min, resets to zero, used in position control only
// RULE3: bias width 0 to 250 reference units, reset value 7
// RULE4: selector 0 torque, 1 speed, 2 acceleration, 3 error, 4 no switching
// RULE5: torque selection is default; P-only when torque exceeds threshold, default 200 %
// RULE6: speed selection gives P-only while speed reference exceeds speed threshold
// RULE7: acceleration selection gives P-only above threshold in 10 (r/min)/s steps; the code compares the raw feedback change per 0.01 ms instead
// RULE8: error selection gives P-only above threshold, only in position control
// RULE9: return to PI automatically when the switch condition clears
// RULE10: autotune config value 0002 disables online autotuning
// RULE11: scale speed feedback by compensation percent, nominal 100
// RULE12: compensation select digit 1 means no feedback compensation
// RULE13: integral time setting counts in 0.01 ms units
// RULE14: P-only freezes the integrator and drops integral action; PI resumes it
module slbm_speed_loop #(
  parameter DW = 16
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  input wire i_position_mode,
  input wire i_sample_valid,
  input wire signed [DW-1:0] i_speed_ref,
  input wire signed [DW-1:0] i_torque_ref,
  input wire signed [DW-1:0] i_position_error,
  input wire signed [DW-1:0] i_speed_feedback,
  output reg signed [DW-1:0] o_speed_ref_biased,
  output reg signed [DW-1:0] o_speed_feedback_comp,
  output reg signed [DW+15:0] o_integrator,
  output reg o_p_only,
  output reg o_autotune_enable,
  output reg o_integ_tick
);
  reg [15:0] bias_amount_q;
  reg [15:0] bias_width_q;
  reg [2:0] mode_select_q;
  reg [15:0] torque_thr_q;
  reg [15:0] speed_thr_q;
  reg [15:0] accel_thr_q;
  reg [15:0] error_thr_q;
  reg [15:0] autotune_cfg_q;
  reg [15:0] comp_percent_q;
  reg [15:0] integ_time_q;
  reg [15:0] int_cnt_q;
  reg signed [DW-1:0] fb_prev_q;
  reg [DW-1:0] accel_q;
  reg [DW-1:0] err_abs;
  reg [DW-1:0] spd_abs;
  reg [DW-1:0] trq_abs;
  reg switch_cond;
  reg signed [DW+16:0] comp_prod;
  reg signed [DW+16:0] comp_scaled;
  reg signed [DW:0] biased_sum;
  reg signed [DW:0] speed_err;
  wire sync_position_mode;
  wire unit_tick;
  wire wr_en;
  wire comp_off;
  wire bias_on;

  // position-mode strap arrives from the drive's mode logic pin
  slbm_sync3 #(.W(1)) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_async(i_position_mode),
    .o_sync(sync_position_mode)
  );

  // 0.01 ms time base for the integral time constant
  slbm_tick_div #(.DIV(`SLBM_INTEG_UNIT_CYC)) u_div (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .o_tick(unit_tick)
  );

  // apb slave answers with zero wait states; writes take effect on the access edge
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign wr_en = i_psel & i_penable & i_pwrite;

  // register writes with range clamping
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      bias_amount_q <= `SLBM_BIAS_AMOUNT_RST;
      bias_width_q <= `SLBM_BIAS_WIDTH_RST;
      mode_select_q <= `SLBM_MODE_SELECT_RST;
      torque_thr_q <= `SLBM_TORQUE_THR_RST;
      speed_thr_q <= 16'h0000;
      accel_thr_q <= 16'h0000;
      error_thr_q <= 16'h0000;
      autotune_cfg_q <= `SLBM_AUTOTUNE_RST;
      comp_percent_q <= `SLBM_COMP_PERCENT_RST;
      integ_time_q <= `SLBM_INTEG_TIME_RST;
    end else if (wr_en) begin
      case (i_paddr)
        `SLBM_REG_BIAS_AMOUNT: begin
          bias_amount_q <= (i_pwdata[15:0] > `SLBM_BIAS_AMOUNT_MAX) ? `SLBM_BIAS_AMOUNT_MAX
                           : i_pwdata[15:0]; // [RULE2]
        end
        `SLBM_REG_BIAS_WIDTH: begin
          bias_width_q <= (i_pwdata[15:0] > `SLBM_BIAS_WIDTH_MAX) ? `SLBM_BIAS_WIDTH_MAX
                          : i_pwdata[15:0]; // [RULE3]
        end
        `SLBM_REG_MODE_SELECT: begin
          mode_select_q <= (i_pwdata[2:0] > `SLBM_SEL_NONE) ? `SLBM_SEL_NONE : i_pwdata[2:0]; // [RULE4]
        end
        `SLBM_REG_TORQUE_THR: torque_thr_q <= i_pwdata[15:0];
        `SLBM_REG_SPEED_THR: speed_thr_q <= i_pwdata[15:0];
        `SLBM_REG_ACCEL_THR: accel_thr_q <= i_pwdata[15:0];
        `SLBM_REG_ERROR_THR: error_thr_q <= i_pwdata[15:0];
        `SLBM_REG_AUTOTUNE_CFG: autotune_cfg_q <= i_pwdata[15:0];
        `SLBM_REG_COMP_PERCENT: comp_percent_q <= i_pwdata[15:0];
        `SLBM_REG_INTEG_TIME: integ_time_q <= i_pwdata[15:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    case (i_paddr)
      `SLBM_REG_BIAS_AMOUNT: o_prdata = {16'h0000, bias_amount_q};
      `SLBM_REG_BIAS_WIDTH: o_prdata = {16'h0000, bias_width_q};
      `SLBM_REG_MODE_SELECT: o_prdata = {29'h0, mode_select_q};
      `SLBM_REG_TORQUE_THR: o_prdata = {16'h0000, torque_thr_q};
      `SLBM_REG_SPEED_THR: o_prdata = {16'h0000, speed_thr_q};
      `SLBM_REG_ACCEL_THR: o_prdata = {16'h0000, accel_thr_q};
      `SLBM_REG_ERROR_THR: o_prdata = {16'h0000, error_thr_q};
      `SLBM_REG_AUTOTUNE_CFG: o_prdata = {16'h0000, autotune_cfg_q};
      `SLBM_REG_COMP_PERCENT: o_prdata = {16'h0000, comp_percent_q};
      `SLBM_REG_INTEG_TIME: o_prdata = {16'h0000, integ_time_q};
      `SLBM_REG_STATUS: o_prdata = {28'h0, o_autotune_enable, bias_on, sync_position_mode, o_p_only};
      default: o_prdata = 32'h0000_0000;
    endcase
  end

  // magnitudes of the detection quantities
  always @* begin
    err_abs = i_position_error[DW-1] ? (~i_position_error + 1'b1) : i_position_error;
    spd_abs = i_speed_ref[DW-1] ? (~i_speed_ref + 1'b1) : i_speed_ref;
    trq_abs = i_torque_ref[DW-1] ? (~i_torque_ref + 1'b1) : i_torque_ref;
  end

  assign bias_on = sync_position_mode & ({{(32-DW){1'b0}}, err_abs} > {16'h0000, bias_width_q}); // [RULE1] [RULE2]
  assign comp_off = (autotune_cfg_q[`SLBM_COMP_DIGIT_LSB+3:`SLBM_COMP_DIGIT_LSB] == `SLBM_COMP_DISABLE);

  // mode switch detection; condition clearing returns to PI by itself
  always @* begin
    case (mode_select_q)
      `SLBM_SEL_TORQUE: switch_cond = ({16'h0000, trq_abs} > {16'h0000, torque_thr_q}); // [RULE5]
      `SLBM_SEL_SPEED: switch_cond = ({16'h0000, spd_abs} > {16'h0000, speed_thr_q}); // [RULE6]
      `SLBM_SEL_ACCEL: switch_cond = ({16'h0000, accel_q} > {16'h0000, accel_thr_q}); // [RULE7]
      `SLBM_SEL_ERROR: switch_cond = sync_position_mode & ({16'h0000, err_abs} > {16'h0000, error_thr_q}); // [RULE8]
      default: switch_cond = 1'b0; // [RULE4]
    endcase
  end

  // acceleration as feedback change per 0.01 ms unit, compared raw rather than in 10 (r/min)/s steps
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      fb_prev_q <= {DW{1'b0}};
      accel_q <= {DW{1'b0}};
    end else if (unit_tick) begin
      fb_prev_q <= i_speed_feedback;
      accel_q <= (i_speed_feedback >= fb_prev_q) ? (i_speed_feedback - fb_prev_q)
                 : (fb_prev_q - i_speed_feedback); // [RULE7]
    end
  end

  // bias addition and feedback compensation datapath
  always @* begin
    biased_sum = {i_speed_ref[DW-1], i_speed_ref};
    if (bias_on) begin
      if (i_position_error[DW-1]) begin
        biased_sum = biased_sum - $signed({1'b0, bias_amount_q[DW-1:0]}); // [RULE1]
      end else begin
        biased_sum = biased_sum + $signed({1'b0, bias_amount_q[DW-1:0]}); // [RULE1]
      end
    end
    comp_prod = i_speed_feedback * $signed({1'b0, comp_percent_q}); // [RULE11]
    comp_scaled = comp_prod / 100; // quotient kept at product width, low word taken below
    speed_err = {o_speed_ref_biased[DW-1], o_speed_ref_biased} - {o_speed_feedback_comp[DW-1], o_speed_feedback_comp};
  end

  // registered outputs updated per sample; autotune enable follows the config every cycle
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_speed_ref_biased <= {DW{1'b0}};
      o_speed_feedback_comp <= {DW{1'b0}};
      o_p_only <= 1'b0;
      o_autotune_enable <= 1'b1;
    end else begin
      o_autotune_enable <= (autotune_cfg_q != `SLBM_AUTOTUNE_OFF); // [RULE10]
      if (i_sample_valid) begin
        o_speed_ref_biased <= biased_sum[DW-1:0];
        o_speed_feedback_comp <= comp_off ? i_speed_feedback : comp_scaled[DW-1:0]; // [RULE11] [RULE12]
        o_p_only <= switch_cond; // [RULE9]
      end
    end
  end

  // integrator steps once every integ_time units of 0.01 ms, frozen in P-only
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      int_cnt_q <= 16'h0000;
      o_integrator <= {(DW+16){1'b0}};
      o_integ_tick <= 1'b0;
    end else begin
      o_integ_tick <= 1'b0;
      if (unit_tick && !o_p_only) begin // [RULE14]
        if (int_cnt_q + 16'h0001 >= integ_time_q) begin // [RULE13]
          int_cnt_q <= 16'h0000;
          o_integrator <= o_integrator + {{15{speed_err[DW]}}, speed_err};
          o_integ_tick <= 1'b1;
        end else begin
          int_cnt_q <= int_cnt_q + 16'h0001;
        end
      end
    end
  end
endmodule // slbm_speed_loop

/* testbench/slbm_speed_loop_assertions.sv */
`timescale 1ns/1ps
`include "slbm_defs.vh"
module slbm_speed_loop_chk #(
  parameter DW = 16
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [31:0] o_prdata,
  input wire i_sample_valid,
  input wire signed [DW-1:0] i_speed_ref,
  input wire signed [DW-1:0] i_torque_ref,
  input wire signed [DW-1:0] i_speed_feedback,
  input wire signed [DW-1:0] o_speed_feedback_comp,
  input wire signed [DW+15:0] o_integrator,
  input wire o_p_only,
  input wire o_autotune_enable,
  input wire o_integ_tick
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  logic [2:0] sel_q;
  logic [15:0] tthr_q, sthr_q, cfg_q;
  // write strobe and magnitudes of the switch inputs
  wire wr = i_psel && i_penable && i_pwrite && o_pready;
  wire [15:0] wd = i_pwdata[15:0];
  wire [DW:0] tabs = (i_torque_ref < 0) ? -i_torque_ref : i_torque_ref;
  wire [DW:0] sabs = (i_speed_ref < 0) ? -i_speed_ref : i_speed_ref;
  // shadow of the switch settings, updated on the same edge as the register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sel_q <= `SLBM_MODE_SELECT_RST;
      tthr_q <= `SLBM_TORQUE_THR_RST;
      sthr_q <= 16'h0000;
      cfg_q <= `SLBM_AUTOTUNE_RST;
    end else if (wr) begin
      if (i_paddr == `SLBM_REG_MODE_SELECT) sel_q <= (wd[2:0] > 3'h4) ? 3'h4 : wd[2:0];
      if (i_paddr == `SLBM_REG_TORQUE_THR) tthr_q <= wd;
      if (i_paddr == `SLBM_REG_SPEED_THR) sthr_q <= wd;
      if (i_paddr == `SLBM_REG_AUTOTUNE_CFG) cfg_q <= wd;
    end
  end
  // a sample taken with a given detection source
  sequence smp_sel(logic [2:0] s);
    i_sample_valid && sel_q == s;
  endsequence
  apb_answer_a: assert property (o_pready && !o_pslverr)
    else $error("bus answer not ready or error");
  unmapped_zero_a: assert property (i_psel && i_penable && !i_pwrite && i_paddr == 8'h30 |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  torque_switch_a: assert property (smp_sel(3'h0) ##0 (tabs > tthr_q) |=> o_p_only)
    else $error("torque over threshold kept PI");
  torque_return_a: assert property (smp_sel(3'h0) ##0 (tabs <= tthr_q) |=> !o_p_only)
    else $error("torque under threshold kept P");
  speed_switch_a: assert property (smp_sel(3'h1) ##0 (sabs > sthr_q) |=> o_p_only)
    else $error("speed over threshold kept PI");
  speed_return_a: assert property (smp_sel(3'h1) ##0 (sabs <= sthr_q) |=> !o_p_only)
    else $error("speed under threshold kept P");
  switch_off_a: assert property (smp_sel(3'h4) |=> !o_p_only)
    else $error("switching while disabled");
  comp_bypass_a: assert property (i_sample_valid && cfg_q[7:4] == 4'h1 |=> o_speed_feedback_comp == $past(i_speed_feedback))
    else $error("feedback compensated while off");
  tune_off_a: assert property ((cfg_q == `SLBM_AUTOTUNE_OFF) [*3] |-> !o_autotune_enable)
    else $error("autotune still enabled");
  integ_hold_a: assert property (o_p_only && $past(o_p_only) |-> $stable(o_integrator))
    else $error("integrator moved in P mode");
  integ_step_a: assert property (!o_integ_tick |-> $stable(o_integrator))
    else $error("integrator moved without a step");
  integ_tick_a: assert property (o_integ_tick |-> !$past(o_p_only))
    else $error("integrator stepped in P mode");
endmodule // slbm_speed_loop_chk
bind slbm_speed_loop slbm_speed_loop_chk #(.DW(DW)) u_chk (.*);

/* testbench/slbm_host_model.sv */
`timescale 1ns/1ps
// host and encoder side: one sample per request, data lines toggle once released
module slbm_host_model (
  input wire i_core_clk,
  input wire i_go,
  input wire [63:0] i_vals,
  output logic o_sample_valid = 1'b0,
  output logic [63:0] o_vals = 64'h0
);
  always @(posedge i_core_clk) begin
    o_sample_valid <= i_go;
    o_vals <= i_go ? i_vals : ~o_vals; // stale data never looks valid
  end
endmodule // slbm_host_model

/* testbench/slbm_speed_loop_tb.sv */
`timescale 1ns/1ps
`include "slbm_defs.vh"
module slbm_speed_loop_tb;
  logic i_core_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_position_mode = 0, go = 0, sv_seen = 0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rd;
  logic [63:0] vals = 64'h0;
  logic [15:0] s, f;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_p_only, o_autotune_enable, o_integ_tick, i_sample_valid;
  wire signed [15:0] i_speed_ref, i_torque_ref, i_position_error, i_speed_feedback;
  wire signed [15:0] o_speed_ref_biased, o_speed_feedback_comp;
  wire signed [31:0] o_integrator;
  logic [32:0] notes[$];
  int fail_count = 0, compares = 0, t0 = 0;
  logic [39:0] rv[8] = '{40'h0000000000, 40'h0400000007, 40'h0800000000, 40'h0c000000c8,
    40'h1c00000000, 40'h2000000064, 40'h24000007d0, 40'h3000000000};
  logic [31:0] cl[3] = '{32'h1c2, 32'hfa, 32'h4};
  logic [59:0] sw[8] = '{60'h001_0000_00c9_0000, 60'h000_0000_ff38_0000, 60'h101_0065_0000_0000,
    60'h100_ff9c_0000_0000, 60'h400_0000_03e8_0000, 60'h300_0000_0000_0064, 60'h311_0000_0000_0064,
    60'h200_0000_0000_0000};
  logic [15:0] be[4] = '{16'h0008, 16'hfff8, 16'h0007, 16'hfff9};
  logic [15:0] bo[4] = '{16'h0032, 16'hffce, 16'h0000, 16'h0000};
  always #2.5 i_core_clk = ~i_core_clk;
  slbm_speed_loop #(.DW(16)) i_dut (.*);
  slbm_host_model i_host (.i_core_clk(i_core_clk), .i_go(go), .i_vals(vals), .o_sample_valid(i_sample_valid),
    .o_vals({i_speed_ref, i_torque_ref, i_position_error, i_speed_feedback}));
  task automatic check(string n, logic [32:0] seen, logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one bus transfer, held until ready is seen
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    rd = o_prdata;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  // request one sample and note what must come back
  task automatic smp(logic [15:0] sr, tr, er, fb, logic p, logic [15:0] b, c);
    notes.push_back({p, b, c});
    @(posedge i_core_clk);
    go <= 1;
    vals <= {sr, tr, er, fb};
    @(posedge i_core_clk);
    go <= 0;
    repeat (3) @(posedge i_core_clk);
  endtask
  // compare each datapath result with the oldest note
  always @(posedge i_core_clk) sv_seen <= i_sample_valid;
  always @(negedge i_core_clk) begin
    if (sv_seen) check("datapath", {o_p_only, o_speed_ref_biased, o_speed_feedback_comp}, notes.pop_front());
  end
  initial begin
    #100000;
    fail_count++;
    summarize;
  end
  initial begin
    void'($urandom(32'h44f3468b));
    repeat (20) @(posedge i_core_clk);
    i_reset <= 0;
    foreach (rv[i]) begin
      apb(0, rv[i][39:32], 32'h0);
      check("reset value", rd, rv[i][31:0]);
    end
    check("autotune on", o_autotune_enable, 1);
    for (int i = 0; i < 3; i++) begin
      apb(1, 8'(i * 4), 32'hffff);
      apb(0, 8'(i * 4), 32'h0);
      check("clamp", rd, cl[i]);
    end
    apb(1, `SLBM_REG_BIAS_AMOUNT, 32'h0);
    apb(1, `SLBM_REG_BIAS_WIDTH, 32'h7);
    $display("test registers done");
    apb(1, `SLBM_REG_SPEED_THR, 32'h64);
    apb(1, `SLBM_REG_ERROR_THR, 32'h5);
    apb(1, `SLBM_REG_ACCEL_THR, 32'hffff);
    foreach (sw[i]) begin
      apb(1, `SLBM_REG_MODE_SELECT, {28'h0, sw[i][59:56]});
      i_position_mode <= sw[i][52];
      repeat (6) @(posedge i_core_clk);
      smp(sw[i][47:32], sw[i][31:16], sw[i][15:0], 16'h0, sw[i][48], sw[i][47:32], 16'h0);
    end
    $display("test mode switch done");
    apb(1, `SLBM_REG_MODE_SELECT, 32'h4);
    apb(1, `SLBM_REG_BIAS_AMOUNT, 32'h32);
    i_position_mode <= 1;
    repeat (6) @(posedge i_core_clk);
    for (int i = 0; i < 4; i++) begin
      s = 16'($urandom % 1000);
      smp(s, 16'h0, be[i], 16'h0, 1'b0, s + bo[i], 16'h0);
    end
    i_position_mode <= 0;
    repeat (6) @(posedge i_core_clk);
    smp(s, 16'h0, 16'h0064, 16'h0, 1'b0, s, 16'h0);
    $display("test bias done");
    apb(1, `SLBM_REG_COMP_PERCENT, 32'h5a);
    f = 16'($urandom % 2000);
    smp(16'h0, 16'h0, 16'h0, f, 1'b0, 16'h0, 16'(32'(f) * 90 / 100));
    apb(1, `SLBM_REG_AUTOTUNE_CFG, 32'h10);
    smp(16'h0, 16'h0, 16'h0, f, 1'b0, 16'h0, f);
    apb(1, `SLBM_REG_AUTOTUNE_CFG, 32'h2);
    repeat (3) @(posedge i_core_clk);
    check("autotune off", o_autotune_enable, 0);
    $display("test compensation done");
    // integral time of one unit: the integrator steps once per 0.01 ms
    apb(1, `SLBM_REG_INTEG_TIME, 32'h1);
    @(negedge i_core_clk);
    t0 = 0;
    while (o_integ_tick !== 1'b1 && t0 < 5000) begin
      @(negedge i_core_clk);
      t0++;
    end
    t0 = 0;
    do begin
      @(negedge i_core_clk);
      t0++;
    end while (o_integ_tick !== 1'b1 && t0 < 5000);
    check("integ period", t0, `SLBM_INTEG_UNIT_CYC);
    $display("test integrator done");
    summarize;
  end
endmodule // slbm_speed_loop_tb
